// ==== verilog/ipf_cfg.svh ====
// Purpose: offsets, field positions and reset values of the priority fields
// Assumes: 16-bit registers on a plain strobe port
// Notes: definitions only
`ifndef IPF_CFG_SVH
`define IPF_CFG_SVH
`define IPF_ADDR_W 4
`define IPF_OFS_CAPDMA 4'h0
`define IPF_OFS_TMRTWI 4'h1
`define IPF_FIELD_W 3
`define IPF_LSB_F3 12
`define IPF_LSB_F2 8
`define IPF_LSB_F1 4
`define IPF_LSB_F0 0
`define IPF_FIELD_RESET 3'h4
`define IPF_IMPL_MASK 16'h7777
`endif

// ==== verilog/ipf_pkg.sv ====
// Purpose: types shared by the priority field block
// Assumes: nothing
// Notes: constants live in ipf_cfg.svh
package ipf_pkg;
   typedef logic [2:0] ipf_level_t;
   typedef logic [15:0] ipf_word_t;
endpackage

// ==== verilog/ipf_field.sv ====
// Purpose: one 3-bit priority field with its request gate
// Assumes: write enable already decoded for this field
// Notes: level zero masks the source
`timescale 1ns/1ps
`include "ipf_cfg.svh"
module ipf_field (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic writeEn,
   input wire ipf_pkg::ipf_level_t writeVal,
   input wire logic srcReq,
   output ipf_pkg::ipf_level_t level,
   output logic reqOut
);
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         level <= `IPF_FIELD_RESET;
      end else if (writeEn) begin
         level <= writeVal;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reqOut <= 1'b0;
      end else begin
         // 000 disables, 001..111 keep the source live
         reqOut <= srcReq && (level != 3'h0);
      end
   end
endmodule

// ==== verilog/ipf_regs.sv ====
// Notes on behaviour
// - Field code 111 means priority level 7, the highest.
// - Field code 001 means level 1, lowest enabled; codes between scale linearly.
// - Field code 000 disables the source; it never requests.
// - Bits 15, 11, 7 and 3 are unimplemented and read zero.
// - Second register: timer 8 14-12, master 10-8, slave 6-4, timer 7 2-0.
// - First register: capture 5, 4, 3 in 14-12, 10-8, 6-4; DMA done 2-0.
// - Reset loads every field with 100 and clears unused bits.
//
// Purpose: two priority control registers feeding per-source level outputs
// Assumes: synchronous source request levels from the same clock domain
// Notes: outputs are registered; a request shows its level one cycle after the field
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ipf_cfg.svh"
module ipf_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [`IPF_ADDR_W-1:0] addr,
   input wire logic [15:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output ipf_pkg::ipf_word_t rdData,
   input wire logic [7:0] srcReq,
   output logic [7:0] srcActive,
   output logic [23:0] srcLevel,
   output ipf_pkg::ipf_level_t topLevel,
   output logic [2:0] topSource,
   output logic topValid
);
   // Source order: 0 dma, 1 cap3, 2 cap4, 3 cap5, 4 tmr7, 5 slave, 6 master, 7 tmr8
   localparam int LSB [4] = '{`IPF_LSB_F0, `IPF_LSB_F1, `IPF_LSB_F2, `IPF_LSB_F3};
   ipf_pkg::ipf_level_t level [8];
   logic [7:0] gated;
   logic wrCapDma;
   logic wrTmrTwi;
   ipf_pkg::ipf_word_t capDmaWord;
   ipf_pkg::ipf_word_t tmrTwiWord;
   ipf_pkg::ipf_level_t next_topLevel;
   logic [2:0] next_topSource;

   assign wrCapDma = wrStb && (addr == `IPF_OFS_CAPDMA);
   assign wrTmrTwi = wrStb && (addr == `IPF_OFS_TMRTWI);

   for (genvar i = 0; i < 8; i++) begin : g_field
      ipf_field u_field (
         .clock(clock),
         .rst_n(rst_n),
         .writeEn(i < 4 ? wrCapDma : wrTmrTwi),
         .writeVal(wrData[LSB[i%4] +: 3]),
         .srcReq(srcReq[i]),
         .level(level[i]),
         .reqOut(gated[i])
      );
   end

   always_comb begin
      capDmaWord = 16'h0000;
      tmrTwiWord = 16'h0000;
      for (int k = 0; k < 4; k++) begin
         capDmaWord[LSB[k] +: 3] = level[k];
         tmrTwiWord[LSB[k] +: 3] = level[k+4];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdData <= 16'h0000;
      end else if (rdStb) begin
         case (addr)
            `IPF_OFS_CAPDMA: rdData <= capDmaWord & `IPF_IMPL_MASK;
            `IPF_OFS_TMRTWI: rdData <= tmrTwiWord & `IPF_IMPL_MASK;
            default: rdData <= 16'h0000;
         endcase
      end else begin
         rdData <= 16'h0000;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         srcActive <= 8'h00;
         srcLevel <= 24'h000000;
      end else begin
         srcActive <= gated;
         for (int k = 0; k < 8; k++) begin
            srcLevel[3*k +: 3] <= gated[k] ? level[k] : 3'h0;
         end
      end
   end

   // Highest numeric level wins; ties go to the lowest source index
   always_comb begin
      next_topLevel = 3'h0;
      next_topSource = 3'h0;
      for (int k = 0; k < 8; k++) begin
         if (gated[k] && level[k] > next_topLevel) begin
            next_topLevel = level[k];
            next_topSource = 3'(k);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         topLevel <= 3'h0;
         topSource <= 3'h0;
         topValid <= 1'b0;
      end else begin
         topLevel <= next_topLevel;
         topSource <= next_topSource;
         topValid <= |gated;
      end
   end

   AST_RESET_FIELDS: assert property (@(posedge clock)
      !rst_n |=> (level[0] == 3'h4 && level[7] == 3'h4))
      else $error("field not at reset level");
   AST_UNUSED_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
      rdStb |=> (rdData & 16'h8888) == 16'h0000)
      else $error("unimplemented bit read nonzero");
   AST_WRITE_READ: assert property (@(posedge clock) disable iff (!rst_n)
      (wrStb && addr == `IPF_OFS_TMRTWI) ##1 (rdStb && addr == `IPF_OFS_TMRTWI && !wrStb)
      |=> rdData == ($past(wrData, 2) & 16'h7777))
      else $error("readback differs from write");
   AST_CAP_FIELD: assert property (@(posedge clock) disable iff (!rst_n)
      wrCapDma |=> level[3] == $past(wrData[14:12]))
      else $error("capture 5 field misplaced");
   AST_TMR_FIELD: assert property (@(posedge clock) disable iff (!rst_n)
      wrTmrTwi |=> level[4] == $past(wrData[2:0]))
      else $error("timer 7 field misplaced");
   AST_DISABLED: assert property (@(posedge clock) disable iff (!rst_n)
      level[0] == 3'h0 |=> ##1 !srcActive[0])
      else $error("disabled source active");
   AST_ENABLED_LOW: assert property (@(posedge clock) disable iff (!rst_n)
      (level[1] == 3'h1 && srcReq[1]) |=> ##1 srcActive[1])
      else $error("level 1 source not active");
   AST_TOP_SEVEN: assert property (@(posedge clock) disable iff (!rst_n)
      (gated[7] && level[7] == 3'h7) |=> (topValid && topLevel == 3'h7))
      else $error("level 7 did not win");

   // Assertion helpers only; nothing here reaches a port
   logic [23:0] levelBus;
   logic [7:0] fieldLive;
   logic [7:0] outranks;
   logic [7:0] tieBelow;
   logic allAtReset;

   always_comb begin
      levelBus = 24'h000000;
      fieldLive = 8'h00;
      allAtReset = 1'b1;
      for (int k = 0; k < 8; k++) begin
         levelBus[3*k +: 3] = level[k];
         fieldLive[k] = (level[k] != 3'h0);
         if (level[k] != `IPF_FIELD_RESET) begin
            allAtReset = 1'b0;
         end
      end
   end

   // A wrong winner shows as a gated source above it, or an equal one below it
   always_comb begin
      outranks = 8'h00;
      tieBelow = 8'h00;
      for (int k = 0; k < 8; k++) begin
         outranks[k] = gated[k] && (level[k] > next_topLevel);
         tieBelow[k] = gated[k] && (level[k] == next_topLevel) && (3'(k) < next_topSource);
      end
   end

   AST_RESET_ALL: assert property (@(posedge clock)
      !rst_n |=> allAtReset)
      else $error("a field missed its reset level");
   AST_RESET_OUTS: assert property (@(posedge clock)
      !rst_n |=> (rdData == 16'h0000 && srcActive == 8'h00 && srcLevel == 24'h000000 && !topValid))
      else $error("outputs not cleared by reset");
   AST_IDLE_READ: assert property (@(posedge clock) disable iff (!rst_n)
      !rdStb |=> rdData == 16'h0000)
      else $error("read data outside its cycle");
   AST_READ_CAPDMA: assert property (@(posedge clock) disable iff (!rst_n)
      (rdStb && addr == `IPF_OFS_CAPDMA) |=> rdData == {1'b0, $past(level[3]), 1'b0,
         $past(level[2]), 1'b0, $past(level[1]), 1'b0, $past(level[0])})
      else $error("first register read misplaced");
   AST_READ_TMRTWI: assert property (@(posedge clock) disable iff (!rst_n)
      (rdStb && addr == `IPF_OFS_TMRTWI) |=> rdData == {1'b0, $past(level[7]), 1'b0,
         $past(level[6]), 1'b0, $past(level[5]), 1'b0, $past(level[4])})
      else $error("second register read misplaced");
   AST_READ_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n)
      (rdStb && addr != `IPF_OFS_CAPDMA && addr != `IPF_OFS_TMRTWI) |=> rdData == 16'h0000)
      else $error("unmapped read nonzero");
   AST_WRITE_CAPDMA: assert property (@(posedge clock) disable iff (!rst_n)
      wrCapDma |=> levelBus[11:0] == $past({wrData[14:12], wrData[10:8], wrData[6:4],
         wrData[2:0]}))
      else $error("first register write landed wrong");
   AST_WRITE_TMRTWI: assert property (@(posedge clock) disable iff (!rst_n)
      wrTmrTwi |=> levelBus[23:12] == $past({wrData[14:12], wrData[10:8], wrData[6:4],
         wrData[2:0]}))
      else $error("second register write landed wrong");
   AST_CAPDMA_KEEPS: assert property (@(posedge clock) disable iff (!rst_n)
      wrCapDma |=> $stable(levelBus[23:12]))
      else $error("first register write disturbed second");
   AST_TMRTWI_KEEPS: assert property (@(posedge clock) disable iff (!rst_n)
      wrTmrTwi |=> $stable(levelBus[11:0]))
      else $error("second register write disturbed first");
   AST_NO_WRITE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
      !(wrCapDma || wrTmrTwi) |=> $stable(levelBus))
      else $error("field changed without a write");
   AST_CAPDMA_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
      (wrCapDma ##1 (rdStb && addr == `IPF_OFS_CAPDMA && !wrStb))
      |=> rdData == ($past(wrData, 2) & `IPF_IMPL_MASK))
      else $error("first register readback differs");
   AST_LIVE_GATED: assert property (@(posedge clock) disable iff (!rst_n)
      $past(rst_n) |-> gated == $past(srcReq & fieldLive))
      else $error("request gate wrong");
   AST_ACTIVE_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
      $past(rst_n) |-> srcActive == $past(gated))
      else $error("active output lags wrongly");
   AST_LEVEL_MASKED: assert property (@(posedge clock) disable iff (!rst_n)
      ($past(rst_n) && !$past(gated[0])) |-> srcLevel[2:0] == 3'h0)
      else $error("idle source shows a level");
   AST_LEVEL_SHOWN: assert property (@(posedge clock) disable iff (!rst_n)
      ($past(rst_n) && $past(gated[7])) |-> srcLevel[23:21] == $past(level[7]))
      else $error("active source level wrong");
   AST_VALID_ANY: assert property (@(posedge clock) disable iff (!rst_n)
      $past(rst_n) |-> topValid == ($past(gated) != 8'h00))
      else $error("winner valid flag wrong");
   AST_NONE_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
      !topValid |-> (topLevel == 3'h0 && topSource == 3'h0))
      else $error("winner shown with no request");
   AST_NO_OUTRANK: assert property (@(posedge clock) disable iff (!rst_n)
      outranks == 8'h00)
      else $error("a higher level lost");
   AST_TIE_LOW: assert property (@(posedge clock) disable iff (!rst_n)
      tieBelow == 8'h00)
      else $error("tie not given to lowest index");
   AST_WINNER_REAL: assert property (@(posedge clock) disable iff (!rst_n)
      next_topLevel != 3'h0 |-> (gated[next_topSource] && level[next_topSource] == next_topLevel))
      else $error("winner not a live source");
   AST_TOP_REG: assert property (@(posedge clock) disable iff (!rst_n)
      $past(rst_n) |-> (topLevel == $past(next_topLevel) && topSource == $past(next_topSource)))
      else $error("winner output not registered");
endmodule

// ==== bench/ipf_testbench.sv ====
// Purpose: self-checking bench for the two priority registers and request outputs
// Assumes: fields at 4*i in {reg1,reg0}, source i in srcReq bit i
// Notes: random data from a fixed seed; corner words first
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wrData = 16'h0000;
   logic wrStb = 1'b0;
   logic rdStb = 1'b0;
   logic [7:0] srcReq = 8'h00;
   ipf_pkg::ipf_word_t rdData;
   logic [7:0] srcActive;
   logic [23:0] srcLevel;
   ipf_pkg::ipf_level_t topLevel;
   logic [2:0] topSource;
   logic topValid;
   integer seed = 15;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   logic [31:0] regs = 32'h44444444;
   logic [15:0] corner [4] = '{16'hFFFF, 16'h0000, 16'h1111, 16'h7654};
   always #20 clock = ~clock;
   ipf_regs dut_u (.clock(clock), .rst_n(rst_n), .addr(addr), .wrData(wrData),
      .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .srcReq(srcReq),
      .srcActive(srcActive), .srcLevel(srcLevel), .topLevel(topLevel),
      .topSource(topSource), .topValid(topValid));
   task end_sim;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Ceiling well above the roughly 480 cycles the sequence needs
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         end_sim();
      end
   end
   task cmp(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge clock);
      wrStb <= 1'b0;
      if (a < 4'h2) regs[a[0]*16 +: 16] = d & 16'h7777;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clock);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clock);
      rdStb <= 1'b0;
      #1 cmp(24'(rdData), 24'((a < 4'h2) ? regs[a[0]*16 +: 16] : 16'h0000));
   endtask
   // Read strobe follows the write strobe with no idle cycle between
   task wr_rd(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge clock);
      wrStb <= 1'b0;
      rdStb <= 1'b1;
      if (a < 4'h2) regs[a[0]*16 +: 16] = d & 16'h7777;
      @(posedge clock);
      rdStb <= 1'b0;
      #1 cmp(24'(rdData), 24'((a < 4'h2) ? regs[a[0]*16 +: 16] : 16'h0000));
   endtask
   function automatic logic [2:0] fld(input int i);
      return regs[4*i +: 3];
   endfunction
   task outs;
      logic [7:0] act;
      logic [23:0] lvl;
      logic [2:0] tl;
      logic [2:0] ts;
      act = 8'h00;
      lvl = 24'h000000;
      tl = 3'h0;
      ts = 3'h0;
      repeat (3) @(posedge clock);
      #1;
      for (int i = 0; i < 8; i++) begin
         if (srcReq[i] && fld(i) != 3'h0) begin
            act[i] = 1'b1;
            lvl[3*i +: 3] = fld(i);
            // Strict compare keeps ties on the lowest index
            if (fld(i) > tl) begin
               tl = fld(i);
               ts = 3'(i);
            end
         end
      end
      cmp(24'(srcActive), 24'(act));
      cmp(srcLevel, lvl);
      cmp(24'(topValid), 24'(act != 8'h00));
      cmp(24'({topLevel, topSource}), 24'({tl, ts}));
   endtask
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rd(4'h0);
      rd(4'h1);
      rd(4'hF);
      for (int k = 0; k < 24; k++) begin
         wr(4'h0, k < 4 ? corner[k] : 16'($random(seed)));
         wr(4'h1, k < 4 ? corner[k] : 16'($random(seed)));
         wr(4'h5, 16'($random(seed)));
         rd(4'h0);
         rd(4'h1);
         if (k >= 4) begin
            wr_rd(4'h0, 16'($random(seed)));
            wr_rd(4'h1, 16'($random(seed)));
         end
         @(posedge clock);
         srcReq <= k < 4 ? 8'hFF : 8'($random(seed));
         outs();
      end
      @(posedge clock);
      rst_n <= 1'b0;
      @(posedge clock);
      rst_n <= 1'b1;
      regs = 32'h44444444;
      rd(4'h0);
      rd(4'h1);
      outs();
      end_sim();
   end
endmodule
